// ===== common/capture_params.svh
// offsets, field positions, reset values and counts for the capture channel
`ifndef CAPTURE_PARAMS_SVH
`define CAPTURE_PARAMS_SVH
`define ADDR_CONTROL 4'h0
`define ADDR_BUFFER 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_IRQ_EN 4'h3
`define ADDR_IRQ_CLR 4'h4
`define ADDR_TIMEBASE 4'h5
`define CTL_IDLE_STOP 13
`define CTL_TSEL_HI 12
`define CTL_TSEL_LO 10
`define CTL_CPI_HI 6
`define CTL_CPI_LO 5
`define CTL_OVF 4
`define CTL_BNE 3
`define CTL_MODE_HI 2
`define CTL_MODE_LO 0
`define CTL_WRITE_MASK 16'h3C67
`define CTL_RESET 16'h0000
`define PRESCALE_4 5'h04
`define PRESCALE_16 5'h10
`define STAT_CAPTURE 0
`define STAT_OVERFLOW 1
`define STAT_WAKE 2
`define STAT_BAD_TB 3
`define IRQ_BITS 4
`endif

// ===== common/capture_pkg.sv
// types shared by the capture channel modules
package capture_pkg;
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_ANY_EDGE = 3'h1,
    MODE_FALL = 3'h2,
    MODE_RISE = 3'h3,
    MODE_RISE4 = 3'h4,
    MODE_RISE16 = 3'h5,
    MODE_DISABLED = 3'h6,
    MODE_WAKE = 3'h7
  } capture_mode_t;
  typedef enum logic [2:0] {
    TB_T3 = 3'h0,
    TB_T2 = 3'h1,
    TB_T4 = 3'h2,
    TB_T5 = 3'h3,
    TB_T1 = 3'h4,
    TB_RES5 = 3'h5,
    TB_RES6 = 3'h6,
    TB_PERIPH = 3'h7
  } timebase_sel_t;
endpackage

// ===== common/capture_fifo_if.sv
// push/pop carrier between channel core and capture buffer
interface capture_fifo_if #(parameter int WIDTH = 16);
  logic push;
  logic [WIDTH-1:0] push_data;
  logic pop;
  logic [WIDTH-1:0] pop_data;
  logic nonempty;
  logic full;
  modport core (output push, push_data, pop, input pop_data, nonempty, full);
  modport buffer (input push, push_data, pop, output pop_data, nonempty, full);
endinterface

// ===== hdl/capture_buffer.sv
// small capture buffer memory with registered read data
module capture_buffer #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  capture_fifo_if.buffer fifo
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
  logic [AW-1:0] wr_q; // write pointer
  logic [AW-1:0] rd_q; // read pointer
  logic [AW:0] cnt_q; // fill count
  logic [WIDTH-1:0] out_q; // registered oldest word
  logic do_push;
  logic do_pop;
  // a push into a full buffer is dropped unless a pop frees a slot in the same cycle; the core flags overflow
  assign do_push = fifo.push && (!fifo.full || fifo.pop);
  assign do_pop = fifo.pop && (cnt_q != '0);
  assign fifo.nonempty = (cnt_q != '0);
  assign fifo.full = (cnt_q == (AW+1)'(DEPTH));
  assign fifo.pop_data = out_q;
  // storage has no reset; only pointers and count carry control state
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_q[wr_q] <= fifo.push_data;
    end
  end
  // pointers and count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (do_pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  // read data register, loaded on a pop with the oldest word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_q <= '0;
    end else if (do_pop) begin
      out_q <= mem_q[rd_q];
    end
  end
endmodule // capture_buffer

// ===== hdl/edge_prescaler.sv
// edge detection and prescale counting for the capture pin
`include "capture_params.svh"
module edge_prescaler
  import capture_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic run_in,
  input capture_mode_t mode_in,
  output logic event_out,
  output logic rise_out
);
  logic pin_q; // previous pin level
  logic [4:0] pre_q; // rising edge prescale counter
  logic rise;
  logic fall;
  assign rise = pin_in && !pin_q;
  assign fall = !pin_in && pin_q;
  assign rise_out = rise;
  // pin history
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_in;
    end
  end
  // prescaler restarts whenever the channel is not running a prescaled mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_q <= '0;
    end else if (!run_in || (mode_in != MODE_RISE4 && mode_in != MODE_RISE16)) begin
      pre_q <= '0;
    end else if (rise) begin
      if (pre_q == ((mode_in == MODE_RISE4) ? `PRESCALE_4 : `PRESCALE_16) - 5'h01) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + 5'h01;
      end
    end
  end
  // capture event decode per mode
  always_comb begin
    event_out = 1'b0;
    if (run_in) begin
      case (mode_in)
        MODE_ANY_EDGE: event_out = rise || fall;
        MODE_FALL: event_out = fall;
        MODE_RISE: event_out = rise;
        MODE_RISE4: event_out = rise && (pre_q == `PRESCALE_4 - 5'h01);
        MODE_RISE16: event_out = rise && (pre_q == `PRESCALE_16 - 5'h01);
        default: event_out = 1'b0;
      endcase
    end
  end
endmodule // edge_prescaler

// ===== hdl/input_capture_control.sv
// input capture channel: control register, timebase select, buffer, interrupt
//
// The implementer's own choices: the register offsets and the plain strobed port.
`include "capture_params.svh"
// Summary of operation
// - idle-stop bit halts channel during CPU idle
// - timebase select field picks capture clock source
// - timer1 timebase only valid when synchronous
// - captures-per-interrupt sets interrupt rate one to four
// - rate ignored in any-edge and wake modes
// - overflow flag read-only, set on buffer overflow
// - not-empty flag shows unread captures remain
// - wake mode: rising-edge interrupt in sleep/idle only
// - mode 110 disables channel
// - mode 101 captures every 16th rising edge
// - mode 100 captures every 4th rising edge
// - mode 011 captures every rising edge
// - mode 010 captures every falling edge
// - mode 001 captures on both edges
// - mode 000 switches channel off
// - unimplemented control bits read as zero
// - status flags hardware driven, zero at reset
module input_capture_control
  import capture_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int TB_WIDTH = 16
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  // register port
  input wire logic [3:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [15:0] RDATA_OUT,
  // capture pin and cpu power state
  input wire logic CAPTURE_PIN_IN,
  input wire logic CPU_IDLE_IN,
  input wire logic CPU_SLEEP_IN,
  // timebase values
  input wire logic [TB_WIDTH-1:0] TIMEBASE1_IN,
  input wire logic TIMEBASE1_SYNC_IN,
  input wire logic [TB_WIDTH-1:0] TIMEBASE2_IN,
  input wire logic [TB_WIDTH-1:0] TIMEBASE3_IN,
  input wire logic [TB_WIDTH-1:0] TIMEBASE4_IN,
  input wire logic [TB_WIDTH-1:0] TIMEBASE5_IN,
  // interrupt
  output logic IRQ_OUT
);
  logic [15:0] ctl_q; // software-written control bits
  logic ovf_q; // buffer overflow flag
  logic [1:0] cpi_cnt_q; // captures since last interrupt
  logic [TB_WIDTH-1:0] tb_run_q; // free-running peripheral clock count
  logic [`IRQ_BITS-1:0] stat_q; // sticky event status
  logic [`IRQ_BITS-1:0] irq_en_q; // interrupt enables
  logic [15:0] rdata_q; // read data register
  logic irq_q; // interrupt output register
  logic pop_pend_q; // buffer pop issued last cycle; data now valid
  capture_mode_t mode;
  timebase_sel_t tsel;
  logic [1:0] cpi;
  logic run; // channel active this cycle
  logic tb_ok; // timebase choice is usable
  logic [TB_WIDTH-1:0] tb_value; // selected timebase
  logic cap_event; // qualifying capture edge
  logic pin_rise;
  logic wake_event;
  logic rate_hit; // interrupt due from rate counter
  logic wr_ctl;
  logic rd_buf;
  logic [`IRQ_BITS-1:0] stat_set;
  logic [`IRQ_BITS-1:0] stat_clr;
  logic [15:0] ctl_view;
  capture_fifo_if #(.WIDTH(TB_WIDTH)) fifo ();

  assign mode = capture_mode_t'(ctl_q[`CTL_MODE_HI:`CTL_MODE_LO]);
  assign tsel = timebase_sel_t'(ctl_q[`CTL_TSEL_HI:`CTL_TSEL_LO]);
  assign cpi = ctl_q[`CTL_CPI_HI:`CTL_CPI_LO];
  assign wr_ctl = WR_IN && (ADDR_IN == `ADDR_CONTROL);
  assign rd_buf = RD_IN && (ADDR_IN == `ADDR_BUFFER);

  // timebase mux; reserved codes and an unsynchronised timer1 give no source
  always_comb begin
    tb_value = '0;
    tb_ok = 1'b1;
    case (tsel)
      TB_PERIPH: tb_value = tb_run_q;
      TB_T1: begin
        tb_value = TIMEBASE1_IN;
        tb_ok = TIMEBASE1_SYNC_IN;
      end
      TB_T5: tb_value = TIMEBASE5_IN;
      TB_T4: tb_value = TIMEBASE4_IN;
      TB_T2: tb_value = TIMEBASE2_IN;
      TB_T3: tb_value = TIMEBASE3_IN;
      default: tb_ok = 1'b0; // reserved
    endcase
  end

  // channel runs unless halted in idle, in sleep, in wake mode or without a valid source
  assign run = tb_ok && !(ctl_q[`CTL_IDLE_STOP] && CPU_IDLE_IN)
    && !CPU_SLEEP_IN && mode != MODE_WAKE;

  edge_prescaler u_edge (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .pin_in(CAPTURE_PIN_IN),
    .run_in(run),
    .mode_in(mode),
    .event_out(cap_event),
    .rise_out(pin_rise)
  );

  capture_buffer #(.DEPTH(DEPTH), .WIDTH(TB_WIDTH)) u_buf (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .fifo(fifo)
  );

  // wake mode ignores every other control bit, rising edges only
  assign wake_event = (mode == MODE_WAKE) && pin_rise && (CPU_SLEEP_IN || CPU_IDLE_IN);

  // push the timebase on each capture; a read pops the oldest entry
  assign fifo.push = cap_event;
  assign fifo.push_data = tb_value;
  assign fifo.pop = rd_buf;

  // rate counter hit: every n-th capture, or every capture where ignored
  assign rate_hit = cap_event && ((mode == MODE_ANY_EDGE) || (cpi_cnt_q == cpi));

  // peripheral clock count used as the fast timebase
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tb_run_q <= '0;
    end else begin
      tb_run_q <= tb_run_q + TB_WIDTH'(1);
    end
  end

  // control register; only writable fields are kept
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctl_q <= `CTL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= WDATA_IN & `CTL_WRITE_MASK;
    end
  end

  // captures-per-interrupt counter; restarts on any control write, or in off and disabled modes
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cpi_cnt_q <= 2'h0;
    end else if (wr_ctl || mode == MODE_OFF || mode == MODE_DISABLED) begin
      cpi_cnt_q <= 2'h0;
    end else if (cap_event) begin
      cpi_cnt_q <= (cpi_cnt_q == cpi) ? 2'h0 : cpi_cnt_q + 2'h1;
    end
  end

  // overflow: set when a capture meets a full buffer; cleared once drained
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ovf_q <= 1'b0;
    end else if (cap_event && fifo.full && !rd_buf) begin
      ovf_q <= 1'b1;
    end else if (!fifo.nonempty || mode == MODE_OFF) begin
      ovf_q <= 1'b0;
    end
  end

  // sticky status; set wins over a clear in the same cycle
  assign stat_set[`STAT_CAPTURE] = rate_hit;
  assign stat_set[`STAT_OVERFLOW] = cap_event && fifo.full && !rd_buf;
  assign stat_set[`STAT_WAKE] = wake_event;
  assign stat_set[`STAT_BAD_TB] = !tb_ok && mode != MODE_OFF && mode != MODE_WAKE;
  assign stat_clr = (WR_IN && ADDR_IN == `ADDR_IRQ_CLR) ? WDATA_IN[`IRQ_BITS-1:0] : '0;
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
    end
  end

  // interrupt enable register
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_en_q <= '0;
    end else if (WR_IN && ADDR_IN == `ADDR_IRQ_EN) begin
      irq_en_q <= WDATA_IN[`IRQ_BITS-1:0];
    end
  end

  // level interrupt, registered so the pin comes from a flop
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((stat_q & ~stat_clr) | stat_set) & irq_en_q);
    end
  end
  assign IRQ_OUT = irq_q;

  // control view with live hardware flags
  always_comb begin
    ctl_view = ctl_q;
    // the flag clears a cycle after the buffer drains; hide it in that gap
    ctl_view[`CTL_OVF] = ovf_q && fifo.nonempty;
    ctl_view[`CTL_BNE] = fifo.nonempty;
  end

  // buffer pop data appear one cycle after the read, from the buffer register
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pop_pend_q <= 1'b0;
    end else begin
      pop_pend_q <= rd_buf && fifo.nonempty;
    end
  end

  // read mux; unmapped addresses return zero
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdata_q <= '0;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `ADDR_CONTROL: rdata_q <= ctl_view;
        `ADDR_STATUS: rdata_q <= 16'(stat_q);
        `ADDR_IRQ_EN: rdata_q <= 16'(irq_en_q);
        `ADDR_TIMEBASE: rdata_q <= 16'(tb_value);
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // buffer word bypasses the mux: the buffer register already holds it
  always_comb begin
    RDATA_OUT = rdata_q;
    if (pop_pend_q) begin
      RDATA_OUT = 16'(fifo.pop_data);
    end
  end
endmodule // input_capture_control

// ===== dv/capture_pin_model.sv
// capture pin source model: bursts of toggles at a chosen pace
module capture_pin_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // burst request
  input wire logic start_in,
  input wire logic [5:0] edges_in,
  input wire logic [1:0] gap_in,
  // pin side
  output logic pin_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] left_q; // toggles still owed
  logic [1:0] wait_q; // idle cycles before next toggle
  // pin holds its level between toggles, as a real driver does
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out <= 1'b0;
      left_q <= 6'h00;
      wait_q <= 2'h0;
    end else if (start_in) begin
      left_q <= edges_in;
      wait_q <= gap_in;
    end else if (left_q != 6'h00) begin
      if (wait_q == 2'h0) begin
        pin_out <= ~pin_out;
        left_q <= left_q - 6'h01;
        wait_q <= gap_in;
      end else begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
  assign busy_out = (left_q != 6'h00); // burst in progress
endmodule // capture_pin_model

// ===== dv/input_capture_control_monitor.sv
// port checker for the capture channel register port and interrupt
`include "capture_params.svh"
module input_capture_control_monitor (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  // register port
  input wire logic [3:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [15:0] RDATA_OUT,
  // interrupt
  input wire logic IRQ_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  logic [15:0] ctl_q; // shadow of writable control bits
  logic [3:0] en_q; // shadow of interrupt enable
  // shadows follow bus writes only, so flags set by hardware stay out
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctl_q <= 16'h0000;
      en_q <= 4'h0;
    end else if (WR_IN) begin
      if (ADDR_IN == `ADDR_CONTROL) ctl_q <= WDATA_IN & `CTL_WRITE_MASK;
      if (ADDR_IN == `ADDR_IRQ_EN) en_q <= WDATA_IN[3:0];
    end
  end
  sequence s_rd(logic [3:0] a);
    RD_IN && ADDR_IN == a;
  endsequence
  a_rdata_idle: assert property (!RD_IN |=> RDATA_OUT == 16'h0000)
    else $error("read data not zero outside read");
  a_ctl_unimpl: assert property (s_rd(`ADDR_CONTROL) |=>
    RDATA_OUT[15:14] == 2'h0 && RDATA_OUT[9:7] == 3'h0)
    else $error("unimplemented control bits not zero");
  a_ctl_readback: assert property (s_rd(`ADDR_CONTROL) |=>
    (RDATA_OUT & `CTL_WRITE_MASK) == $past(ctl_q))
    else $error("control readback wrong");
  a_unmapped_zero: assert property (RD_IN && ADDR_IN > 4'h5 |=> RDATA_OUT == 16'h0000)
    else $error("unmapped read not zero");
  a_en_readback: assert property (s_rd(`ADDR_IRQ_EN) |=> RDATA_OUT == {12'h000, $past(en_q)})
    else $error("enable readback wrong");
  a_ovf_needs_data: assert property (s_rd(`ADDR_CONTROL) |=>
    !(RDATA_OUT[`CTL_OVF] && !RDATA_OUT[`CTL_BNE]))
    else $error("overflow shown with empty buffer");
  a_irq_enabled: assert property (IRQ_OUT |-> (en_q | $past(en_q)) != 4'h0)
    else $error("interrupt with no enable");
  a_irq_holds: assert property (IRQ_OUT && !WR_IN && !$past(WR_IN) |=> IRQ_OUT)
    else $error("interrupt dropped without a write");
endmodule // input_capture_control_monitor
bind input_capture_control input_capture_control_monitor u_monitor (
  .CORE_CLK_IN, .RESETN_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .IRQ_OUT
);

// ===== dv/tb_input_capture_control.sv
// self-checking bench for the capture channel
`include "capture_params.svh"
module tb_input_capture_control
  import capture_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, start = 1'b0;
  logic idle = 1'b0, sleep = 1'b0, sync1 = 1'b1, pin, irq, busy;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic [15:0] tb3 = 16'h3333; // timer3 value, stepped to tell captures apart
  logic [5:0] edges = 6'h00;
  logic [1:0] gap = 2'h0;
  int num_errors = 0, checks_done = 0;
  logic [15:0] tbv [5] = '{16'h3333, 16'h2222, 16'h4444, 16'h5555, 16'h1111}; // by select
  capture_mode_t mode_tab [7] = '{MODE_ANY_EDGE, MODE_FALL, MODE_RISE, MODE_RISE4,
    MODE_RISE16, MODE_DISABLED, MODE_OFF};
  logic [2:0] tsel_tab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0};
  logic [5:0] tog_tab [7] = '{6'h02, 6'h02, 6'h02, 6'h08, 6'h20, 6'h02, 6'h02};
  int cnt_tab [7] = '{2, 1, 1, 1, 1, 0, 0}; // captures per row
  // 125 MHz
  always #4 clk = ~clk;
  input_capture_control uut (
    .CORE_CLK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CAPTURE_PIN_IN(pin),
    .CPU_IDLE_IN(idle), .CPU_SLEEP_IN(sleep), .TIMEBASE1_IN(16'h1111),
    .TIMEBASE1_SYNC_IN(sync1), .TIMEBASE2_IN(16'h2222), .TIMEBASE3_IN(tb3),
    .TIMEBASE4_IN(16'h4444), .TIMEBASE5_IN(16'h5555), .IRQ_OUT(irq)
  );
  capture_pin_model u_pin (
    .clk_in(clk), .rst_n_in(rst_n), .start_in(start), .edges_in(edges),
    .gap_in(gap), .pin_out(pin), .busy_out(busy)
  );
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stands only in the cycle after the read strobe
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
    input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, e, rdata & m);
  endtask
  // pin burst; extra cycles let the pin history flop and push land
  task automatic burst(input logic [5:0] n, input logic [1:0] g);
    @(posedge clk);
    edges <= n;
    gap <= g;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int k = 0; k < 300 && (busy || k < 2); k++) begin
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`ADDR_CONTROL, 16'hFFFF, 16'h0000, "ctl reset");
    wr_reg(`ADDR_CONTROL, 16'hFFFF);
    rd_reg(`ADDR_CONTROL, 16'hFFFF, 16'h3C67, "ctl bits");
    rd_reg(4'hF, 16'hFFFF, 16'h0000, "unmapped");
    // every mode but wake, own timebase and pace per row
    for (int i = 0; i < 7; i++) begin
      v = tbv[tsel_tab[i]];
      wr_reg(`ADDR_CONTROL, {3'h0, tsel_tab[i], 7'h00, mode_tab[i]});
      burst(tog_tab[i], 2'(i));
      rd_reg(`ADDR_CONTROL, 16'h0008, (cnt_tab[i] > 0) ? 16'h0008 : 16'h0000, "bne");
      for (int k = 0; k < cnt_tab[i]; k++)
        rd_reg(`ADDR_BUFFER, 16'hFFFF, v, "cap");
      rd_reg(`ADDR_BUFFER, 16'hFFFF, 16'h0000, "drained");
    end
    rd_reg(`ADDR_TIMEBASE, 16'hFFFF, 16'h3333, "timebase");
    // five rising edges into four slots, each with its own timer value
    wr_reg(`ADDR_CONTROL, 16'h0003);
    for (int j = 0; j < 5; j++) begin
      @(posedge clk);
      tb3 <= 16'h3330 + 16'(j);
      burst(6'h02, 2'h0);
    end
    rd_reg(`ADDR_CONTROL, 16'h0018, 16'h0018, "full flags");
    for (int k = 0; k < 4; k++)
      rd_reg(`ADDR_BUFFER, 16'hFFFF, 16'h3330 + 16'(k), "oldest");
    rd_reg(`ADDR_BUFFER, 16'hFFFF, 16'h0000, "dropped");
    rd_reg(`ADDR_CONTROL, 16'h0018, 16'h0000, "empty flags");
    @(posedge clk);
    tb3 <= 16'h3333;
    sync1 <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      wr_reg(`ADDR_CONTROL, j ? 16'h1403 : 16'h1003);
      burst(6'h02, 2'h1);
      rd_reg(`ADDR_CONTROL, 16'h0008, 16'h0000, "no source");
    end
    rd_reg(`ADDR_STATUS, 16'h0008, 16'h0008, "bad source");
    @(posedge clk);
    idle <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      wr_reg(`ADDR_CONTROL, j ? 16'h0003 : 16'h2003);
      burst(6'h02, 2'h2);
      rd_reg(`ADDR_BUFFER, 16'hFFFF, j ? 16'h3333 : 16'h0000, "idle cap");
    end
    @(posedge clk);
    idle <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      sleep <= j[0];
      wr_reg(`ADDR_IRQ_CLR, 16'h000F);
      wr_reg(`ADDR_CONTROL, 16'h0067);
      burst(6'h02, 2'h0);
      rd_reg(`ADDR_STATUS, 16'h0005, j ? 16'h0004 : 16'h0000, "wake");
    end
    @(posedge clk);
    sleep <= 1'b0;
    wr_reg(`ADDR_IRQ_CLR, 16'h000F);
    wr_reg(`ADDR_IRQ_EN, 16'h0001);
    wr_reg(`ADDR_CONTROL, 16'h0023);
    burst(6'h02, 2'h3);
    chk("irq first", 16'h0000, {15'h0000, irq});
    burst(6'h02, 2'h3);
    chk("irq second", 16'h0001, {15'h0000, irq});
    // every fourth capture: three edges stay quiet, the fourth fires
    wr_reg(`ADDR_IRQ_CLR, 16'h0001);
    wr_reg(`ADDR_CONTROL, 16'h0063);
    burst(6'h06, 2'h1);
    chk("irq third", 16'h0000, {15'h0000, irq});
    burst(6'h02, 2'h1);
    chk("irq fourth", 16'h0001, {15'h0000, irq});
    wr_reg(`ADDR_IRQ_CLR, 16'h0001);
    wr_reg(`ADDR_CONTROL, 16'h0061);
    burst(6'h01, 2'h0);
    chk("irq any", 16'h0001, {15'h0000, irq});
    wr_reg(`ADDR_IRQ_EN, 16'h0000);
    burst(6'h01, 2'h0);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    rd_reg(`ADDR_STATUS, 16'h0001, 16'h0001, "sticky");
    // reset in mid-run with unread captures and sticky bits left over
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`ADDR_CONTROL, 16'hFFFF, 16'h0000, "ctl after reset");
    rd_reg(`ADDR_STATUS, 16'hFFFF, 16'h0000, "stat after reset");
    finish_test();
  end
endmodule // tb_input_capture_control
